// ### asa_map.vh
// register indices, field positions and reset values of the alarm status block
`ifndef ASA_MAP_VH
`define ASA_MAP_VH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define ASA_IDX_ALARM_MASK 8'h1D
`define ASA_IDX_GEN_MASK 8'h1E
`define ASA_IDX_ALARM_STATUS 8'h20
`define ASA_IDX_GENERAL_STATUS 8'h21
`define ASA_IDX_FORCE_FAIL 8'h30

// ****************************************************************
// reset values
// ****************************************************************
`define ASA_ALARM_RST 16'h0200
`define ASA_GEN_RST 16'h1180
`define ASA_MASK_RST 16'hFFFF
`define ASA_FORCE_RST 16'h0000

// ****************************************************************
// alarm status fields
// ****************************************************************
`define ASA_AL_GEN_PEND 15
`define ASA_AL_MODEM_PEND 14
`define ASA_AL_SELF_DIAG 13
`define ASA_AL_OSCILLATOR_START_FAILURE 12
`define ASA_AL_CNT_HI 11
`define ASA_AL_CNT_LO 10
`define ASA_AL_TRIM_NLD 9
`define ASA_AL_OTP_CRC 8
`define ASA_AL_FRAME_CRC 7
`define ASA_AL_WDOG 6
`define ASA_AL_VREF 5
`define ASA_AL_AIN1 4
`define ASA_AL_AIN0 3
`define ASA_AL_DIE_TEMP 2
`define ASA_AL_OT_ERR 1
`define ASA_AL_OT_WARN 0

// ****************************************************************
// general status fields
// ****************************************************************
`define ASA_GS_ALARM_PEND 15
`define ASA_GS_MODEM_PEND 14
`define ASA_GS_TRIM_BUSY 12
`define ASA_GS_TEST_TYPE 11

// ****************************************************************
// bit groups
// ****************************************************************
`define ASA_AL_STICKY 16'h01C0
`define ASA_AL_IRQ_FEED 16'h21FF
`define ASA_GENERAL_GROUP_PENDING_FEED 16'h06CF
`define ASA_FORCE_BITS 16'h0023

`endif

// ### asa_sync3.v
// three-stage synchroniser with agreement filter for asynchronous levels
`timescale 1ns/1ns
module asa_sync3 #(
  parameter WIDTH = 4
) (
  input wire i_mclk,
  input wire i_rst,
  input wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_level
);
  reg [WIDTH-1:0] s1_r;
  reg [WIDTH-1:0] s2_r;
  reg [WIDTH-1:0] s3_r;
  reg [WIDTH-1:0] lvl_r;
  wire [WIDTH-1:0] lvl_nxt;

  // a bit moves only once stages two and three agree
  assign lvl_nxt = (s2_r & ~(s2_r ^ s3_r)) | (lvl_r & (s2_r ^ s3_r));

  // first stage feeds the second stage only
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s1_r <= {WIDTH{1'b0}};
      s2_r <= {WIDTH{1'b0}};
      s3_r <= {WIDTH{1'b0}};
      lvl_r <= {WIDTH{1'b0}};
    end else begin
      s1_r <= i_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  assign o_level = lvl_r;
endmodule

// ### asa_top.v
// alarm and general status aggregation with apb register access
//
// Overview of operation
// RULE1: alarm bit 15 is OR of unmasked general bits 10-9, 7-6 and 3-0
// RULE2: bit 14 of both words shows modem pending
// RULE3: alarm bit 13 follows self-diagnostic failure
// RULE4: oscillator failure sets bit 12, alarm only
// RULE5: bits 11-10 show counter, shifted for limit eight
// RULE6: bit 9 resets high, clears after trim loads
// RULE7: otp checksum error sets sticky bit 8
// RULE8: bad frame checksum sets sticky bit 7
// RULE9: watchdog fault sets sticky bit 6
// RULE10: read clears sticky bits unless condition persists
// RULE11: bit 5 is live reference fault or force
// RULE12: bits 4,3,2 follow adc threshold faults
// RULE13: bit 1 is live overtemperature error or force
// RULE14: bit 0 is live temperature warning or force
// RULE15: general bit 15 is OR of unmasked alarm bits 13 and 8-0
// RULE16: general bit 12 shows trim loading busy
// RULE17: general bit 11 shows self-test type
// RULE18: mask one blocks irq and alarm, status still sets
// RULE19: clear only addressed word; same-cycle event survives
`timescale 1ns/1ns
`include "asa_map.vh"
module asa_top #(
  parameter AW = 12
) (
  input wire i_mclk,
  input wire i_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [AW-1:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  input wire i_oscillator_start_failure_pin,
  input wire i_vref_bad_pin,
  input wire i_ot_err_pin,
  input wire i_ot_warn_pin,
  input wire i_self_diag_fail,
  input wire i_ain1_fault,
  input wire i_ain0_fault,
  input wire i_die_temp_fault,
  input wire i_otp_crc_evt,
  input wire i_frame_crc_evt,
  input wire i_wdog_evt,
  input wire [2:0] i_crc_count,
  input wire i_crc_limit_eight,
  input wire i_trim_load_done,
  input wire i_trim_loading,
  input wire i_self_test_type,
  input wire [10:0] i_gen_low_bits,
  input wire i_modem_pending,
  output wire o_gen_read,
  output wire o_irq,
  output wire o_alarm_n
);

  // ****************************************************************
  // helpers
  // ****************************************************************

  // byte address of a register index
  function [AW-1:0] reg_addr;
    input [7:0] idx;
    begin
      reg_addr = {{(AW-10){1'b0}}, idx, 2'b00};
    end
  endfunction

  // any bit set after masking and restricting to feeding bits
  function any_unmasked;
    input [15:0] stat;
    input [15:0] mask;
    input [15:0] feed;
    begin
      any_unmasked = |(stat & ~mask & feed);
    end
  endfunction

  // ****************************************************************
  // declarations
  // ****************************************************************
  wire [3:0] pin_lvl;
  wire oscillator_start_failure;
  wire vref_bad;
  wire ot_err;
  wire ot_warn;
  reg [15:0] alarm_mask_r;
  reg [15:0] gen_mask_r;
  reg [15:0] force_r;
  reg [2:0] sticky_r;
  reg [2:0] sticky_nxt;
  reg trim_nld_r;
  reg [31:0] prdata_r;
  reg pslverr_r;
  reg [15:0] alarm_word;
  reg [15:0] gen_word;
  reg [15:0] alarm_base;
  reg [15:0] gen_base;
  reg [1:0] cnt_view;
  wire [2:0] sticky_evt;
  wire setup_ph;
  wire access_ph;
  wire wr_acc;
  wire rd_acc;
  wire sel_amask;
  wire sel_gmask;
  wire sel_alarm;
  wire sel_gen;
  wire sel_force;
  wire hit;
  wire alarm_pend;
  wire gen_pend;

  // ****************************************************************
  // pin synchronisation
  // ****************************************************************

  // analog flags arrive without relation to the clock
  asa_sync3 #(
    .WIDTH(4)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_async({i_oscillator_start_failure_pin, i_vref_bad_pin, i_ot_err_pin, i_ot_warn_pin}),
    .o_level(pin_lvl)
  );

  assign oscillator_start_failure = pin_lvl[3];
  assign vref_bad = pin_lvl[2];
  assign ot_err = pin_lvl[1];
  assign ot_warn = pin_lvl[0];

  // ****************************************************************
  // apb decode
  // ****************************************************************

  // one access cycle, no wait states
  assign setup_ph = i_psel & ~i_penable;
  assign access_ph = i_psel & i_penable;
  assign wr_acc = access_ph & i_pwrite;
  assign rd_acc = access_ph & ~i_pwrite;

  assign sel_amask = (i_paddr == reg_addr(`ASA_IDX_ALARM_MASK));
  assign sel_gmask = (i_paddr == reg_addr(`ASA_IDX_GEN_MASK));
  assign sel_alarm = (i_paddr == reg_addr(`ASA_IDX_ALARM_STATUS));
  assign sel_gen = (i_paddr == reg_addr(`ASA_IDX_GENERAL_STATUS));
  assign sel_force = (i_paddr == reg_addr(`ASA_IDX_FORCE_FAIL));
  assign hit = sel_amask | sel_gmask | sel_alarm | sel_gen | sel_force;

  // ****************************************************************
  // status words
  // ****************************************************************

  // counter view picks the window that fits the limit
  always @* begin
    if (i_crc_limit_eight) begin
      cnt_view = i_crc_count[2:1]; // RULE5
    end else begin
      cnt_view = i_crc_count[1:0]; // RULE5
    end
  end

  // cross bits use the bases only, so the two words never loop
  always @* begin
    alarm_base = 16'h0000;
    alarm_base[`ASA_AL_SELF_DIAG] = i_self_diag_fail; // RULE3
    alarm_base[`ASA_AL_OSCILLATOR_START_FAILURE] = oscillator_start_failure; // RULE4
    alarm_base[`ASA_AL_CNT_HI:`ASA_AL_CNT_LO] = cnt_view; // RULE5
    alarm_base[`ASA_AL_TRIM_NLD] = trim_nld_r; // RULE6
    alarm_base[`ASA_AL_OTP_CRC] = sticky_r[2]; // RULE7
    alarm_base[`ASA_AL_FRAME_CRC] = sticky_r[1]; // RULE8
    alarm_base[`ASA_AL_WDOG] = sticky_r[0]; // RULE9
    alarm_base[`ASA_AL_VREF] = vref_bad | force_r[`ASA_AL_VREF]; // RULE11
    alarm_base[`ASA_AL_AIN1] = i_ain1_fault; // RULE12
    alarm_base[`ASA_AL_AIN0] = i_ain0_fault; // RULE12
    alarm_base[`ASA_AL_DIE_TEMP] = i_die_temp_fault; // RULE12
    alarm_base[`ASA_AL_OT_ERR] = ot_err | force_r[`ASA_AL_OT_ERR]; // RULE13
    alarm_base[`ASA_AL_OT_WARN] = ot_warn | force_r[`ASA_AL_OT_WARN]; // RULE14
  end

  // general word: low bits come from neighbouring logic
  always @* begin
    gen_base = 16'h0000;
    gen_base[10:0] = i_gen_low_bits;
    gen_base[`ASA_GS_TRIM_BUSY] = i_trim_loading; // RULE16
    gen_base[`ASA_GS_TEST_TYPE] = i_self_test_type; // RULE17
  end

  // masked ors; mask one blocks, status is unaffected
  assign alarm_pend = any_unmasked(alarm_base, alarm_mask_r, `ASA_AL_IRQ_FEED); // RULE18
  assign gen_pend = any_unmasked(gen_base, gen_mask_r, `ASA_GENERAL_GROUP_PENDING_FEED); // RULE18

  // full words as software sees them
  always @* begin
    alarm_word = alarm_base;
    alarm_word[`ASA_AL_GEN_PEND] = gen_pend; // RULE1
    alarm_word[`ASA_AL_MODEM_PEND] = i_modem_pending; // RULE2
    gen_word = gen_base;
    gen_word[`ASA_GS_ALARM_PEND] = alarm_pend; // RULE15
    gen_word[`ASA_GS_MODEM_PEND] = i_modem_pending; // RULE2
  end

  // ****************************************************************
  // sticky faults
  // ****************************************************************
  assign sticky_evt = {i_otp_crc_evt, i_frame_crc_evt, i_wdog_evt};

  // clear only bits that were returned by this read; events always win
  always @* begin
    sticky_nxt = sticky_r;
    if (rd_acc && sel_alarm) begin
      sticky_nxt = sticky_r & ~prdata_r[`ASA_AL_OTP_CRC:`ASA_AL_WDOG]; // RULE10 RULE19
    end else if (wr_acc && sel_alarm) begin
      // write one to clear, the interrupt service path
      sticky_nxt = sticky_r & ~i_pwdata[`ASA_AL_OTP_CRC:`ASA_AL_WDOG];
    end
    sticky_nxt = sticky_nxt | sticky_evt; // RULE7 RULE8 RULE9 RULE19
  end

  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sticky_r <= 3'b000;
    end else begin
      sticky_r <= sticky_nxt;
    end
  end

  // trim flag only ever falls; a reload never raises it again
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      trim_nld_r <= 1'b1; // RULE6
    end else if (i_trim_load_done) begin
      trim_nld_r <= 1'b0; // RULE6
    end
  end

  // ****************************************************************
  // writable registers
  // ****************************************************************

  // masks default to all ones so no maskable status bit fires until enabled
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      alarm_mask_r <= `ASA_MASK_RST; // RULE18
      gen_mask_r <= `ASA_MASK_RST; // RULE18
      force_r <= `ASA_FORCE_RST;
    end else if (wr_acc) begin
      if (sel_amask) begin
        alarm_mask_r <= i_pwdata[15:0];
      end
      if (sel_gmask) begin
        gen_mask_r <= i_pwdata[15:0];
      end
      if (sel_force) begin
        force_r <= i_pwdata[15:0] & `ASA_FORCE_BITS;
      end
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************

  // read data is frozen in the setup cycle; the clear uses this copy
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup_ph) begin
      pslverr_r <= ~hit;
      if (sel_amask) begin
        prdata_r <= {16'h0000, alarm_mask_r};
      end else if (sel_gmask) begin
        prdata_r <= {16'h0000, gen_mask_r};
      end else if (sel_alarm) begin
        prdata_r <= {16'h0000, alarm_word};
      end else if (sel_gen) begin
        prdata_r <= {16'h0000, gen_word};
      end else if (sel_force) begin
        prdata_r <= {16'h0000, force_r};
      end else begin
        prdata_r <= 32'h0000_0000;
      end
    end
  end

  assign o_prdata = prdata_r;
  assign o_pready = access_ph;
  assign o_pslverr = access_ph & pslverr_r;

  // neighbours clear their own sticky general bits on this pulse
  assign o_gen_read = rd_acc & sel_gen; // RULE19

  // ****************************************************************
  // interrupt and alarm outputs
  // ****************************************************************

  // oscillator and trim flags hold alarm but stay off the interrupt
  assign o_irq = alarm_pend | gen_pend | i_modem_pending; // RULE18
  assign o_alarm_n = ~(alarm_pend | oscillator_start_failure | trim_nld_r); // RULE4 RULE6

endmodule

// ### asa_host_model.sv
// apb host model that reaches the status block registers
`timescale 1ns/1ns
module asa_host_model (
  input wire logic i_mclk,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [11:0] o_paddr,
  output logic [31:0] o_pwdata,
  input wire logic [31:0] i_prdata,
  input wire logic i_pready,
  input wire logic i_pslverr
);
  initial begin
    {o_psel, o_penable, o_pwrite} = 3'b000;
    o_paddr = 12'h000;
    o_pwdata = 32'h0000_0000;
  end
  // one transfer, entered just after a rising edge; request stays up so a
  // back-to-back setup can follow without a second assignment in one step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= w ? d : ~d;
    @(posedge i_mclk);
    o_penable <= 1'b1;
    do @(posedge i_mclk); while (i_pready !== 1'b1);
    q = i_prdata;
    e = i_pslverr;
  endtask
  // release the bus for one cycle
  task automatic idle;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    @(posedge i_mclk);
  endtask
endmodule

// ### asa_top_properties.sv
// concurrent checks on the status block ports
`timescale 1ns/1ns
module asa_top_props #(
  parameter AW = 12
) (
  input wire i_mclk,
  input wire i_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [AW-1:0] i_paddr,
  input wire [31:0] o_prdata,
  input wire i_oscillator_start_failure_pin,
  input wire i_self_diag_fail,
  input wire i_ain1_fault,
  input wire i_ain0_fault,
  input wire i_die_temp_fault,
  input wire i_wdog_evt,
  input wire [2:0] i_crc_count,
  input wire i_crc_limit_eight,
  input wire i_trim_load_done,
  input wire i_trim_loading,
  input wire i_self_test_type,
  input wire i_modem_pending,
  input wire o_gen_read,
  input wire o_irq,
  input wire o_alarm_n
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // setup cycles of status reads; a write to the same word must not count as one
  wire rd_al = i_psel && !i_penable && !i_pwrite && (i_paddr == {{(AW-10){1'b0}}, 10'h080});
  wire rd_gs = i_psel && !i_penable && !i_pwrite && (i_paddr == {{(AW-10){1'b0}}, 10'h084});
  wire [1:0] cnt_view = i_crc_limit_eight ? i_crc_count[2:1] : i_crc_count[1:0];
  wire [3:0] live_view = {i_self_diag_fail, i_ain1_fault, i_ain0_fault, i_die_temp_fault};
  wire [1:0] gen_view = {i_trim_loading, i_self_test_type};
  reg trim_seen_r;
  // remembers a finished trim load; before it the alarm pin must stay low
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      trim_seen_r <= 1'b0;
    end else if (i_trim_load_done) begin
      trim_seen_r <= 1'b1;
    end
  end
  a_modem_irq: assert property (i_modem_pending |-> o_irq)
    else $error("modem pending without irq");
  a_modem_bit: assert property ((rd_al || rd_gs) && i_modem_pending |=> o_prdata[14])
    else $error("modem bit missing in status word");
  a_osc_alarm: assert property (i_oscillator_start_failure_pin [*6] |-> !o_alarm_n)
    else $error("oscillator failure left alarm high");
  a_trim_alarm: assert property (!trim_seen_r && !i_trim_load_done |-> !o_alarm_n)
    else $error("alarm released before trim load");
  a_count_view: assert property (rd_al |=> o_prdata[11:10] == $past(cnt_view))
    else $error("counter field wrong");
  a_live_bits: assert property (rd_al |=> {o_prdata[13], o_prdata[4:2]} == $past(live_view))
    else $error("live fault bits wrong");
  a_gen_fields: assert property (rd_gs |=> o_prdata[12:11] == $past(gen_view))
    else $error("general busy or test type wrong");
  a_sticky_set: assert property (i_wdog_evt ##1 rd_al |=> o_prdata[6])
    else $error("watchdog event not captured");
  a_read_clear: assert property ((rd_al && !i_wdog_evt) ##1 !i_wdog_evt ##1 rd_al |=> !o_prdata[6])
    else $error("sticky bit survived read");
  a_event_wins: assert property (rd_al ##1 (i_penable && i_wdog_evt) ##1 rd_al |=> o_prdata[6])
    else $error("event during read was lost");
  a_gen_read_pulse: assert property (rd_gs |=> o_gen_read)
    else $error("general read pulse missing");
  a_gen_read_scope: assert property (rd_al |=> !o_gen_read)
    else $error("general read pulse on alarm read");
  c_read: cover property (rd_al ##1 i_penable);
  c_irq: cover property (o_irq);
  c_alarm_release: cover property (!o_alarm_n ##1 o_alarm_n);
endmodule
bind asa_top asa_top_props #(.AW(AW)) asa_top_props_inst (.i_mclk(i_mclk), .i_rst(i_rst),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .o_prdata(o_prdata),
  .i_oscillator_start_failure_pin(i_oscillator_start_failure_pin), .i_self_diag_fail(i_self_diag_fail),
  .i_ain1_fault(i_ain1_fault), .i_ain0_fault(i_ain0_fault), .i_die_temp_fault(i_die_temp_fault),
  .i_wdog_evt(i_wdog_evt), .i_crc_count(i_crc_count), .i_crc_limit_eight(i_crc_limit_eight),
  .i_trim_load_done(i_trim_load_done), .i_trim_loading(i_trim_loading),
  .i_self_test_type(i_self_test_type), .i_modem_pending(i_modem_pending),
  .o_gen_read(o_gen_read), .o_irq(o_irq),
  .o_alarm_n(o_alarm_n));

// ### test_alarm_status_aggregator.sv
// self-checking bench for the alarm status block
`timescale 1ns/1ns
`include "asa_map.vh"
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin n_fail++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module test_alarm_status_aggregator;
  localparam logic [11:0] A_AL = 12'(`ASA_IDX_ALARM_STATUS) << 2;
  localparam logic [11:0] A_GS = 12'(`ASA_IDX_GENERAL_STATUS) << 2;
  localparam logic [11:0] A_AM = 12'(`ASA_IDX_ALARM_MASK) << 2;
  localparam logic [11:0] A_GM = 12'(`ASA_IDX_GEN_MASK) << 2;
  localparam logic [11:0] A_FF = 12'(`ASA_IDX_FORCE_FAIL) << 2;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic psel, pen, pwr, pready, pslverr, last_err, gen_read, irq, alarm_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic osc, vref, oterr, otwarn, sdiag, ain1, ain0, dtemp, otp_e, frm_e, wd_e, lim8;
  logic tdone, tload, ttype, modem;
  logic [2:0] cnt;
  logic [10:0] glow;
  int n_fail = 0;
  int n_compared = 0;
  asa_top #(.AW(12)) asa_top_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_oscillator_start_failure_pin(osc), .i_vref_bad_pin(vref),
    .i_ot_err_pin(oterr), .i_ot_warn_pin(otwarn), .i_self_diag_fail(sdiag),
    .i_ain1_fault(ain1), .i_ain0_fault(ain0), .i_die_temp_fault(dtemp), .i_otp_crc_evt(otp_e),
    .i_frame_crc_evt(frm_e), .i_wdog_evt(wd_e), .i_crc_count(cnt), .i_crc_limit_eight(lim8),
    .i_trim_load_done(tdone), .i_trim_loading(tload), .i_self_test_type(ttype),
    .i_gen_low_bits(glow), .i_modem_pending(modem), .o_gen_read(gen_read), .o_irq(irq),
    .o_alarm_n(alarm_n));
  asa_host_model asa_host_model_inst (.i_mclk(i_mclk), .o_psel(psel), .o_penable(pen),
    .o_pwrite(pwr), .o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata), .i_pready(pready),
    .i_pslverr(pslverr));
  // 20 MHz clock
  initial forever #25 i_mclk = ~i_mclk;
  // read one word and compare; b2b keeps the bus for a following setup
  task automatic rc(input logic [11:0] a, input logic [15:0] e, input bit b2b);
    asa_host_model_inst.xfer(1'b0, a, 32'h0000_0000, q, last_err);
    if (!b2b) asa_host_model_inst.idle();
    `CHK($sformatf("reg %h", a), {16'h0000, e}, q)
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    asa_host_model_inst.xfer(1'b1, a, {16'h0000, d}, q, last_err);
    asa_host_model_inst.idle();
  endtask
  // flags are looked at mid-cycle, away from the edge that updates them
  task automatic chkf(input string n, input logic e, ref logic s);
    @(negedge i_mclk);
    `CHK(n, e, s)
    @(posedge i_mclk);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  task automatic report_and_stop;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard, far beyond the hundred-odd cycles the tests need
  initial begin
    #(50 * 3000);
    n_fail++;
    report_and_stop();
  end
  initial begin
    {osc, vref, oterr, otwarn, sdiag, ain1, ain0, dtemp, otp_e, frm_e, wd_e, lim8} = '0;
    {tdone, ttype, modem} = 3'b000;
    tload = 1'b1;
    cnt = 3'b000;
    glow = 11'h180;
    tick(8);
    i_rst <= 1'b0;
    tick(1);
    rc(A_AL, `ASA_ALARM_RST, 0);
    rc(A_GS, `ASA_GEN_RST, 0);
    chkf("alarm_n", 1'b0, alarm_n);
    tload <= 1'b0;
    tdone <= 1'b1;
    tick(1);
    tdone <= 1'b0;
    rc(A_AL, 16'h0000, 0);
    rc(A_GS, 16'h0180, 0);
    chkf("alarm_n", 1'b1, alarm_n);
    $display("test reset_trim done");
    {otp_e, frm_e, wd_e} <= 3'b111;
    tick(1);
    {otp_e, frm_e, wd_e} <= 3'b000;
    rc(A_AL, 16'h01C0, 1);
    rc(A_AL, 16'h0000, 0);
    wd_e <= 1'b1;
    tick(1);
    rc(A_AL, 16'h0040, 1);
    rc(A_AL, 16'h0040, 0);
    wd_e <= 1'b0;
    rc(A_AL, 16'h0040, 0);
    rc(A_AL, 16'h0000, 0);
    $display("test sticky done");
    {sdiag, ain1, ain0, dtemp} <= 4'b1111;
    cnt <= 3'b110;
    rc(A_AL, 16'h281C, 0);
    lim8 <= 1'b1;
    rc(A_AL, 16'h2C1C, 0);
    {sdiag, ain1, ain0, dtemp} <= 4'b0101;
    cnt <= 3'b001;
    rc(A_AL, 16'h0014, 0);
    {sdiag, ain1, ain0, dtemp} <= 4'b0000;
    $display("test live fields done");
    modem <= 1'b1;
    glow <= 11'h181;
    rc(A_AL, 16'h4000, 0);
    chkf("irq", 1'b1, irq);
    wr(A_GM, 16'hFFFE);
    ttype <= 1'b1;
    rc(A_AL, 16'hC000, 0);
    rc(A_GS, 16'h4981, 0);
    {modem, ttype} <= 2'b00;
    glow <= 11'h180;
    wr(A_GM, 16'hFFFF);
    wd_e <= 1'b1;
    tick(1);
    wd_e <= 1'b0;
    chkf("irq", 1'b0, irq);
    wr(A_AM, 16'hFFBF);
    rc(A_AM, 16'hFFBF, 0);
    chkf("irq", 1'b1, irq);
    rc(A_GS, 16'h8180, 0);
    wr(A_AL, 16'h0040);
    chkf("irq", 1'b0, irq);
    $display("test masks done");
    wr(A_FF, 16'hFFFF);
    rc(A_FF, 16'h0023, 0);
    rc(A_AL, 16'h0023, 0);
    wr(A_FF, 16'h0000);
    // only the oscillator bit unmasked; it pulls alarm low but stays off the irq
    wr(A_AM, 16'hEFFF);
    {osc, vref, oterr, otwarn} <= 4'b1111;
    tick(6);
    rc(A_AL, 16'h1023, 0);
    chkf("alarm_n", 1'b0, alarm_n);
    chkf("irq", 1'b0, irq);
    {osc, vref, oterr, otwarn} <= 4'b0000;
    tick(6);
    rc(A_AL, 16'h0000, 0);
    rc(12'h100, 16'h0000, 0);
    `CHK("pslverr", 1'b1, last_err)
    $display("test pins done");
    report_and_stop();
  end
endmodule
